// *** lsfs_pkg.sv ***
package lsfs_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_LOSS_NS = 6000;
  localparam int FSET_SHORT_NS = 6000;
  localparam int CHECK_NS = 10000;
  localparam int FLAG_PULSE_NS = 1000;
  localparam int CNT_W = 11;

  function automatic logic [CNT_W-1:0] lsfs_cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : lsfs_cyc_min

  localparam logic [CNT_W-1:0] SYNC_LOSS_CYC = lsfs_cyc_min(SYNC_LOSS_NS);
  localparam logic [CNT_W-1:0] FSET_SHORT_CYC = lsfs_cyc_min(FSET_SHORT_NS);
  localparam logic [CNT_W-1:0] CHECK_CYC = lsfs_cyc_min(CHECK_NS);
  localparam logic [CNT_W-1:0] FLAG_PULSE_CYC = lsfs_cyc_min(FLAG_PULSE_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

  // ***********************************************************
  // widths and reset values
  // ***********************************************************
  localparam int NUM_STRINGS = 10;
  localparam logic [NUM_STRINGS-1:0] STRINGS_NONE = 10'h000;
  localparam int CMP_W = 5;

  typedef enum logic [2:0] {
    LSFS_OFF = 3'h0,
    LSFS_CHECK = 3'h1,
    LSFS_PULSE = 3'h2,
    LSFS_RUN = 3'h3,
    LSFS_FAULT = 3'h4
  } lsfs_state_t;

  typedef struct packed {
    logic input_overcurrent;
    logic switch_current_limit;
    logic output_overvoltage_trip;
    logic switch_node_overvoltage;
    logic led_short_fail;
  } lsfs_cmp_t;

  typedef struct packed {
    logic input_overcurrent;
    logic switch_node_overvoltage;
    logic fset_short;
    logic led_short_fail;
    logic startup_fault;
    logic illegal_action;
    logic output_overvoltage_trip;
  } lsfs_status_t;

  localparam lsfs_status_t STATUS_CLEAR = 7'h00;

endpackage : lsfs_pkg

// *** lsfs_sync.sv ***
`timescale 1ns/1ps
module lsfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // active-low async reset
  input wire logic clk_en, // freezes state when low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised copy
);

  logic [W-1:0] meta;

  // meta is read only by q
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : lsfs_sync

// *** lsfs_sequencer.sv ***
`timescale 1ns/1ps
// Functional notes
// R01 - start only with enable high, supply good
// R02 - stay off while sync pin low
// R03 - fault check first; pulse flag on pass
// R04 - ready low when start-up fault free
// R05 - controller configures strings before turn-on
// R06 - controller clears spurious block after start-up
// R07 - unpopulated string enabled: illegal, all off
// R08 - genuine start-up fault holds flag low
// R09 - controller reads status, skips the clear
// R10 - enable low forces shutdown
// R11 - external sync clock within supported range
// R12 - sync open 6 us: internal clock, no flag
// R13 - sync stuck low: short fault, boost off
// R14 - input overcurrent raises disconnect gate
// R15 - switch limit ends present on-time only
// R16 - overvoltage with open string drops that string
// R17 - switch node overvoltage shuts device off
// R18 - comparators synchronised, causes latched
module lsfs_sequencer
  import lsfs_pkg::*;
(
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic nrst, // active-low async reset
  input wire logic clk_en, // freezes all state but the reset synchroniser when low
  input wire logic enable_pin, // device enable pin
  input wire logic supply_above_undervoltage_lockout, // input above undervoltage_lockout turn-on
  input wire logic freq_set_sync_pin, // sync / frequency_set_resistor pin level
  input wire lsfs_cmp_t cmp_in, // analog comparator outputs
  input wire logic startup_fault_in, // other start-up check failure
  input wire logic [NUM_STRINGS-1:0] string_open_in, // per-string open at overvoltage
  input wire logic [NUM_STRINGS-1:0] string_populated, // strings found at start-up
  input wire logic [NUM_STRINGS-1:0] string_enable_req, // string enables from registers
  input wire logic spurious_clear, // one-cycle clear of start-up block bit
  output logic fault_flag_n, // fault flag, active low
  output logic ready_output_n, // ready for commands, active low
  output logic disconnect_gate, // high turns off input disconnect switch
  output logic boost_enable, // boost stage running
  output logic on_time_end, // end of present switch on-time, high the cycle after each cycle the synchronised limit is high with boost_enable
  output logic ext_sync_active, // switching on external sync clock
  output logic [NUM_STRINGS-1:0] string_on, // strings in regulation
  output lsfs_status_t fault_status // latched fault causes
);

  // ***********************************************************
  // reset release and input synchronisers
  // ***********************************************************
  logic rst_meta;
  logic rst_n;
  lsfs_cmp_t cmp_s;
  logic [NUM_STRINGS-1:0] open_s;
  logic en_s;
  logic undervoltage_lockout_s;
  logic sync_s;
  logic sfault_s;
  logic sync_d;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  lsfs_sync #(.W(CMP_W + NUM_STRINGS + 4)) u_sync ( // R18
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d({cmp_in, string_open_in, enable_pin, supply_above_undervoltage_lockout, freq_set_sync_pin,
        startup_fault_in}),
    .q({cmp_s, open_s, en_s, undervoltage_lockout_s, sync_s, sfault_s})
  );

  // ***********************************************************
  // sync pin supervision
  // ***********************************************************
  logic sync_edge;
  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] low_cnt;
  logic fset_short;
  lsfs_state_t state;
  logic active;

  assign sync_edge = sync_s ^ sync_d;
  assign active = (state != LSFS_OFF);
  assign fset_short = (low_cnt == FSET_SHORT_CYC);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_d <= 1'b0;
      edge_cnt <= CNT_ZERO;
      low_cnt <= CNT_ZERO;
    end else if (clk_en) begin
      sync_d <= sync_s;
      if (sync_edge || !active) begin
        edge_cnt <= CNT_ZERO;
      end else if (edge_cnt != SYNC_LOSS_CYC) begin
        edge_cnt <= edge_cnt + CNT_ONE;
      end
      // a valid clock is never low this long, so this is a short to ground
      if (sync_s || !active) begin
        low_cnt <= CNT_ZERO;
      end else if (low_cnt != FSET_SHORT_CYC) begin
        low_cnt <= low_cnt + CNT_ONE; // R13
      end
    end
  end

  // external clock is taken only if it toggles during the start-up check
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_active <= 1'b0;
    end else if (clk_en) begin
      if (!active) begin
        ext_sync_active <= 1'b0;
      end else if (state == LSFS_CHECK && sync_edge) begin
        ext_sync_active <= 1'b1;
      end else if (edge_cnt == SYNC_LOSS_CYC && sync_s) begin
        ext_sync_active <= 1'b0; // R12
      end
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  logic [CNT_W-1:0] seq_cnt;
  logic hard_fault;
  logic illegal;

  assign illegal = |(string_enable_req & ~string_populated); // R07
  assign hard_fault = cmp_s.switch_node_overvoltage | fset_short | cmp_s.input_overcurrent;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= LSFS_OFF;
      seq_cnt <= CNT_ZERO;
    end else if (clk_en) begin
      if (!en_s) begin
        state <= LSFS_OFF; // R10
        seq_cnt <= CNT_ZERO;
      end else begin
        unique case (state)
          LSFS_OFF: begin
            seq_cnt <= CNT_ZERO;
            if (undervoltage_lockout_s && sync_s) begin
              state <= LSFS_CHECK; // R01 R02
            end
          end
          LSFS_CHECK: begin
            seq_cnt <= seq_cnt + CNT_ONE;
            if (hard_fault || sfault_s) begin
              state <= LSFS_FAULT; // R08
            end else if (seq_cnt == CHECK_CYC) begin
              seq_cnt <= CNT_ZERO;
              state <= cmp_s.led_short_fail ? LSFS_FAULT : LSFS_PULSE; // R03
            end
          end
          LSFS_PULSE: begin
            seq_cnt <= seq_cnt + CNT_ONE;
            if (hard_fault || sfault_s) begin
              state <= LSFS_FAULT; // R08
            end else if (seq_cnt == FLAG_PULSE_CYC) begin
              state <= LSFS_RUN; // R04
            end
          end
          LSFS_RUN: begin
            if (hard_fault) begin
              state <= LSFS_FAULT; // R13 R14 R17
            end
          end
          LSFS_FAULT: begin
            state <= LSFS_FAULT;
          end
          default: begin
            state <= LSFS_OFF;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // fault causes, sticky until shutdown
  // ***********************************************************
  logic start_block;
  logic [NUM_STRINGS-1:0] string_removed;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_status <= STATUS_CLEAR;
    end else if (clk_en) begin
      if (!active) begin
        fault_status <= STATUS_CLEAR;
      end else begin
        fault_status.input_overcurrent <= fault_status.input_overcurrent |
                                          cmp_s.input_overcurrent; // R18
        fault_status.switch_node_overvoltage <= fault_status.switch_node_overvoltage |
                                                cmp_s.switch_node_overvoltage;
        fault_status.fset_short <= fault_status.fset_short | fset_short;
        fault_status.led_short_fail <= fault_status.led_short_fail |
          (state == LSFS_CHECK && seq_cnt == CHECK_CYC && cmp_s.led_short_fail);
        fault_status.startup_fault <= fault_status.startup_fault |
          (sfault_s && (state == LSFS_CHECK || state == LSFS_PULSE));
        fault_status.illegal_action <= fault_status.illegal_action |
                                       (illegal && state == LSFS_RUN); // R07
        fault_status.output_overvoltage_trip <= fault_status.output_overvoltage_trip |
                                                cmp_s.output_overvoltage_trip;
      end
    end
  end

  // strings opened at an overvoltage trip leave regulation, the rest stay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      string_removed <= STRINGS_NONE;
    end else if (clk_en) begin
      if (!active) begin
        string_removed <= STRINGS_NONE;
      end else if (cmp_s.output_overvoltage_trip) begin
        string_removed <= string_removed | (open_s & string_enable_req); // R16
      end
    end
  end

  // leds stay blocked after start-up until the controller clears it;
  // the block is set on entry to run, so a clear in that cycle loses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_block <= 1'b1;
    end else if (clk_en) begin
      if (state != LSFS_RUN) begin
        start_block <= 1'b1;
      end else if (spurious_clear) begin
        start_block <= 1'b0; // R06
      end
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_n <= 1'b1;
      ready_output_n <= 1'b1;
      boost_enable <= 1'b0;
      string_on <= STRINGS_NONE;
    end else if (clk_en) begin
      fault_flag_n <= !(state == LSFS_PULSE || state == LSFS_FAULT); // R03 R08 R13
      ready_output_n <= !(state == LSFS_RUN); // R04
      boost_enable <= (state == LSFS_CHECK || state == LSFS_PULSE || state == LSFS_RUN)
                      && !hard_fault; // R17
      if (state != LSFS_RUN || hard_fault || start_block ||
          fault_status.illegal_action || illegal) begin
        string_on <= STRINGS_NONE; // R07
      end else begin
        string_on <= string_enable_req & ~string_removed; // R16
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      disconnect_gate <= 1'b0;
      on_time_end <= 1'b0;
    end else if (clk_en) begin
      if (!active) begin
        disconnect_gate <= 1'b0;
      end else if (cmp_s.input_overcurrent) begin
        disconnect_gate <= 1'b1; // R14
      end
      // only the present on-time ends; switching carries on next cycle
      on_time_end <= cmp_s.switch_current_limit && boost_enable; // R15
    end
  end

endmodule : lsfs_sequencer

// *** lsfs_props.sv ***
`timescale 1ns/1ps
module lsfs_props
  import lsfs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset, low
  input wire logic clk_en, // run
  input wire logic enable_pin, // enable
  input wire logic supply_above_undervoltage_lockout, // supply good
  input wire logic freq_set_sync_pin, // sync pin
  input wire lsfs_cmp_t cmp_in, // comparators
  input wire logic startup_fault_in, // other fault
  input wire logic [NUM_STRINGS-1:0] string_open_in, // open strings
  input wire logic [NUM_STRINGS-1:0] string_populated, // present
  input wire logic [NUM_STRINGS-1:0] string_enable_req, // requests
  input wire logic spurious_clear, // clear pulse
  input wire logic fault_flag_n, // flag
  input wire logic ready_output_n, // ready
  input wire logic disconnect_gate, // gate
  input wire logic boost_enable, // boost
  input wire logic on_time_end, // on-time end
  input wire logic ext_sync_active, // ext sync
  input wire logic [NUM_STRINGS-1:0] string_on, // lit
  input wire lsfs_status_t fault_status // status
);
  // ***************************************************
  // flag low run length
  // ***************************************************
  logic [CNT_W-1:0] low_cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= CNT_ZERO;
    end else begin
      low_cnt <= fault_flag_n ? CNT_ZERO : low_cnt + CNT_ONE;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  start_gate_a: assert property (
    $rose(boost_enable) |-> $past(enable_pin, 4) && $past(supply_above_undervoltage_lockout, 4)
    && $past(freq_set_sync_pin, 4)) else $error("boost started early");
  pass_pulse_a: assert property (
    $rose(fault_flag_n) && !ready_output_n |-> low_cnt == FLAG_PULSE_CYC + CNT_ONE)
    else $error("flag pulse width off");
  ready_flag_a: assert property (!ready_output_n |-> fault_flag_n)
    else $error("ready with flag low");
  lit_ready_a: assert property (
    string_on != STRINGS_NONE |-> $past(!ready_output_n)) else $error("lit before ready");
  illegal_off_a: assert property (
    fault_status.illegal_action |=> string_on == STRINGS_NONE) else $error("lit after illegal");
  shut_down_a: assert property (
    !enable_pin [*6] |-> !boost_enable && string_on == STRINGS_NONE
    && fault_status == STATUS_CLEAR) else $error("not shut down");
  sync_open_a: assert property (
    $fell(ext_sync_active) && freq_set_sync_pin |-> fault_flag_n) else $error("flag on open");
  fset_stop_a: assert property (fault_status.fset_short |=> !boost_enable)
    else $error("boost on after short");
  gate_cause_a: assert property (
    $rose(disconnect_gate) |-> $past(cmp_in.input_overcurrent, 2)
    || $past(cmp_in.input_overcurrent, 3) || $past(cmp_in.input_overcurrent, 4))
    else $error("gate without overcurrent");
  on_time_a: assert property (
    on_time_end |-> $past(cmp_in.switch_current_limit, 3) && $past(boost_enable))
    else $error("stray on-time end");
  node_ov_a: assert property (
    (cmp_in.switch_node_overvoltage && enable_pin) [*6] |-> !boost_enable)
    else $error("boost on after node overvoltage");
endmodule : lsfs_props
bind lsfs_sequencer lsfs_props i_lsfs_props (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
  .enable_pin(enable_pin), .supply_above_undervoltage_lockout(supply_above_undervoltage_lockout),
  .freq_set_sync_pin(freq_set_sync_pin), .cmp_in(cmp_in), .startup_fault_in(startup_fault_in),
  .string_open_in(string_open_in), .string_populated(string_populated),
  .string_enable_req(string_enable_req), .spurious_clear(spurious_clear),
  .fault_flag_n(fault_flag_n), .ready_output_n(ready_output_n),
  .disconnect_gate(disconnect_gate), .boost_enable(boost_enable), .on_time_end(on_time_end),
  .ext_sync_active(ext_sync_active), .string_on(string_on), .fault_status(fault_status));

// *** lsfs_ctrl_model.sv ***
`timescale 1ns/1ps
module lsfs_ctrl_model
  import lsfs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic ready_output_n, // device ready, low
  input wire logic [1:0] sync_mode, // 0 open, 1 clock, 2 stuck low
  input wire logic [NUM_STRINGS-1:0] want, // strings to light
  output logic freq_set_sync_pin, // sync pin level
  output logic spurious_clear, // one-cycle clear
  output logic [NUM_STRINGS-1:0] string_enable_req // string enables
);
  int div = 0;
  logic ph = 1'b0;
  logic cleared = 1'b0;
  logic clr_q = 1'b0;
  logic [NUM_STRINGS-1:0] req_q = STRINGS_NONE;
  // open pin reads high, so loss of clock is not a short
  assign freq_set_sync_pin = (sync_mode == 2'h1) ? ph : (sync_mode == 2'h0);
  assign spurious_clear = clr_q;
  assign string_enable_req = req_q;
  always @(posedge clk_sys) begin
    div <= (div == 49) ? 0 : div + 1;
    if (div == 49) begin
      ph <= ~ph;
    end
    clr_q <= !ready_output_n && !cleared;
    cleared <= !ready_output_n;
    // configure only once the clear has gone out
    req_q <= (!ready_output_n && cleared) ? want : STRINGS_NONE;
  end
endmodule : lsfs_ctrl_model

// *** led_driver_startup_fault_sequencer_tb.sv ***
`timescale 1ns/1ps
module led_driver_startup_fault_sequencer_tb;
  import lsfs_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, en = 1'b0, undervoltage_lockout = 1'b0, sclr, pin, fl_n, rd_n;
  logic gate, boost, ote, xs, ce = 1'b1, sf = 1'b0;
  lsfs_cmp_t cmp = 5'h00;
  logic [NUM_STRINGS-1:0] opn = '0, pop = '0, want = '0, req, son, b;
  logic [1:0] mode = 2'h0;
  lsfs_status_t st;
  int n_errors = 0, cmp_count = 0;
  logic [31:0] seed = 32'h00000057;
  always #5 clk_sys = ~clk_sys;
  lsfs_sequencer i_lsfs_sequencer (.clk_sys(clk_sys), .nrst(nrst), .clk_en(ce),
    .enable_pin(en), .supply_above_undervoltage_lockout(undervoltage_lockout), .freq_set_sync_pin(pin), .cmp_in(cmp),
    .startup_fault_in(sf), .string_open_in(opn), .string_populated(pop),
    .string_enable_req(req), .spurious_clear(sclr), .fault_flag_n(fl_n),
    .ready_output_n(rd_n), .disconnect_gate(gate), .boost_enable(boost),
    .on_time_end(ote), .ext_sync_active(xs), .string_on(son), .fault_status(st));
  lsfs_ctrl_model i_lsfs_ctrl_model (.clk_sys(clk_sys), .ready_output_n(rd_n),
    .sync_mode(mode), .want(want), .freq_set_sync_pin(pin), .spurious_clear(sclr),
    .string_enable_req(req));
  function automatic logic [NUM_STRINGS-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[NUM_STRINGS-1:0];
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic cmp1(input logic a, input logic e);
    cmp_count++;
    if (a !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
      n_errors++;
    end
  endtask : cmp1
  task automatic cmpv(input logic [15:0] a, input logic [15:0] e);
    cmp_count++;
    if (a !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
      n_errors++;
    end
  endtask : cmpv
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // shutdown, restart, count flag-low cycles until ready
  task automatic power_up(output int w);
    int i;
    en = 1'b0;
    tick(8);
    en = 1'b1;
    w = 0;
    for (i = 0; i < 1300 && rd_n !== 1'b0; i++) begin
      if (fl_n === 1'b0) w++;
      tick(1);
    end
  endtask : power_up
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    int w;
    tick(10);
    nrst = 1'b1;
    tick(3);
    mode = 2'h2;
    undervoltage_lockout = 1'b1;
    en = 1'b1;
    tick(40);
    cmp1(boost, 1'b0);
    mode = 2'h0;
    undervoltage_lockout = 1'b0;
    tick(40);
    cmp1(boost, 1'b0);
    $display("end power gating");
    undervoltage_lockout = 1'b1;
    mode = 2'h1;
    pop = rnd() | 10'h001;
    want = (rnd() & pop) | 10'h001;
    power_up(w);
    cmpv(16'(w), 16'(FLAG_PULSE_CYC + CNT_ONE));
    cmp1(rd_n, 1'b0);
    cmp1(xs, 1'b1);
    tick(6);
    cmpv(16'(son), 16'(want));
    $display("end start-up");
    b = want & (~want + 10'h001);
    opn = b;
    cmp.output_overvoltage_trip = 1'b1;
    tick(6);
    cmp.output_overvoltage_trip = 1'b0;
    opn = '0;
    tick(3);
    cmpv(16'(son), 16'(want & ~b));
    cmp1(st.output_overvoltage_trip, 1'b1);
    w = 0;
    cmp.switch_current_limit = 1'b1;
    tick(1);
    cmp.switch_current_limit = 1'b0;
    repeat (8) begin
      w += int'(ote);
      tick(1);
    end
    cmpv(16'(w), 16'h0001);
    cmp1(boost, 1'b1);
    // a frozen block must not see an overcurrent that ends before it runs again
    ce = 1'b0;
    cmp.input_overcurrent = 1'b1;
    tick(6);
    cmp.input_overcurrent = 1'b0;
    tick(1);
    ce = 1'b1;
    tick(4);
    cmp1(gate, 1'b0);
    $display("end running faults");
    mode = 2'h0;
    tick(SYNC_LOSS_CYC - 60);
    cmp1(xs, 1'b1);
    tick(80);
    cmp1(xs, 1'b0);
    cmp1(fl_n, 1'b1);
    mode = 2'h2;
    tick(FSET_SHORT_CYC - 20);
    cmp1(boost, 1'b1);
    tick(40);
    cmp1(boost, 1'b0);
    cmp1(fl_n, 1'b0);
    cmp1(st.fset_short, 1'b1);
    $display("end sync loss");
    mode = 2'h0;
    en = 1'b0;
    tick(8);
    cmpv(16'(st), 16'(STATUS_CLEAR));
    cmp1(fl_n, 1'b1);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(4);
    cmp1(rd_n, 1'b1);
    en = 1'b1;
    tick(20);
    cmp.input_overcurrent = 1'b1;
    tick(4);
    cmp1(gate, 1'b1);
    cmp.input_overcurrent = 1'b0;
    tick(10);
    cmp1(gate, 1'b1);
    cmp1(fl_n, 1'b0);
    cmp1(st.input_overcurrent, 1'b1);
    $display("end overcurrent");
    cmp.led_short_fail = 1'b1;
    power_up(w);
    cmp.led_short_fail = 1'b0;
    cmp1(rd_n, 1'b1);
    cmp1(fl_n, 1'b0);
    cmp1(st.led_short_fail, 1'b1);
    cmpv(16'(son), 16'h0000);
    pop = 10'h0ff;
    want = ~pop | (rnd() & pop);
    power_up(w);
    tick(8);
    cmp1(st.illegal_action, 1'b1);
    cmpv(16'(son), 16'h0000);
    cmp.switch_node_overvoltage = 1'b1;
    tick(8);
    cmp1(boost, 1'b0);
    cmp1(st.switch_node_overvoltage, 1'b1);
    $display("end illegal and node overvoltage");
    cmp.switch_node_overvoltage = 1'b0;
    sf = 1'b1;
    en = 1'b0;
    tick(8);
    en = 1'b1;
    tick(20);
    sf = 1'b0;
    cmp1(st.startup_fault, 1'b1);
    cmp1(fl_n, 1'b0);
    cmp1(rd_n, 1'b1);
    $display("end start-up fault");
    test_done();
  end
endmodule : led_driver_startup_fault_sequencer_tb
